// ===== cdr_pkg.sv
// package: constants and types for the character display read/reset block
package cdr_pkg;

  // apb register map
  localparam int CDR_ADDR_W = 8;
  localparam int CDR_DATA_W = 32;
  localparam logic [7:0] CDR_OFF_INSTR = 8'h00;
  localparam logic [7:0] CDR_OFF_DATA = 8'h04;
  localparam logic [7:0] CDR_OFF_STATUS = 8'h08;

  // memory sizes and the space fill code
  localparam int CDR_TEXT_DEPTH = 128;
  localparam int CDR_GLYPH_DEPTH = 64;
  localparam logic [7:0] CDR_SPACE_CODE = 8'h20;

  // values after reset
  localparam logic [6:0] CDR_CNT_RST = 7'h00;
  localparam logic [6:0] CDR_SHIFT_RST = 7'h00;
  localparam logic CDR_INC_RST = 1'b1;
  localparam logic CDR_SHIFT_EN_RST = 1'b0;
  localparam logic CDR_DISP_RST = 1'b0;
  localparam logic CDR_CURSOR_RST = 1'b0;
  localparam logic CDR_BLINK_RST = 1'b0;
  localparam logic CDR_WIDTH_RST = 1'b1;
  localparam logic CDR_LINES_RST = 1'b1;
  localparam logic [1:0] CDR_LUM_RST = 2'h0;

  // instruction prefixes, matched on the leading bits of the byte
  localparam logic [7:0] CDR_CMD_CLEAR = 8'h01;
  localparam logic [6:0] CDR_PFX_HOME = 7'h01;
  localparam logic [5:0] CDR_PFX_ENTRY = 6'h01;
  localparam logic [4:0] CDR_PFX_ONOFF = 5'h01;
  localparam logic [3:0] CDR_PFX_CURS = 4'h1;
  localparam logic [2:0] CDR_PFX_FUNC = 3'h1;
  localparam logic [1:0] CDR_PFX_GSET = 2'h1;

  // instruction field positions
  localparam int CDR_EN_INC = 1;
  localparam int CDR_EN_SHIFT = 0;
  localparam int CDR_OO_DISP = 2;
  localparam int CDR_OO_CURSOR = 1;
  localparam int CDR_OO_BLINK = 0;
  localparam int CDR_CS_DISPLAY = 3;
  localparam int CDR_CS_RIGHT = 2;
  localparam int CDR_FN_WIDTH = 4;
  localparam int CDR_FN_LINES = 3;
  localparam int CDR_FN_LUM = 0;

  // status register field positions
  localparam int CDR_ST_MODE = 0;
  localparam int CDR_ST_DISP = 2;
  localparam int CDR_ST_CURSOR = 3;
  localparam int CDR_ST_BLINK = 4;
  localparam int CDR_ST_INC = 5;
  localparam int CDR_ST_SHIFT_EN = 6;
  localparam int CDR_ST_WIDTH = 7;
  localparam int CDR_ST_LINES = 8;
  localparam int CDR_ST_LUM = 9;
  localparam int CDR_ST_GLYPH = 11;
  localparam int CDR_ST_CLEAR = 12;
  localparam int CDR_ST_OFFSET = 16;

  // host port modes taken from the strap
  typedef enum logic [1:0] {
    CDR_MODE_PAR_A = 2'b00,
    CDR_MODE_PAR_B = 2'b01,
    CDR_MODE_SERIAL = 2'b11
  } cdr_mode_t;

endpackage

// ===== cdr_ram_if.sv
// interface: one write and one read port of a byte-wide RAM
`timescale 1ns/1ns
interface cdr_ram_if #(
  parameter int AW = 7
);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface

// ===== cdr_text_ram.sv
// module: display text RAM with host port and refresh scan port
`timescale 1ns/1ns
module cdr_text_ram #(
  parameter int DEPTH = 128
)(
  // clock
  input wire logic pclk,
  // host side
  cdr_ram_if.mem bus,
  // refresh scan
  input wire logic [$clog2(DEPTH)-1:0] scan_addr,
  output logic [7:0] scan_char
);
  logic [7:0] mem [DEPTH];
  logic [7:0] scan_q;

  // no reset on the array; the control side sweeps it with spaces
  always_ff @(posedge pclk)
  begin
    if (bus.we)
      mem[bus.waddr] <= bus.wdata;
    scan_q <= mem[scan_addr];
  end

  assign bus.rdata = mem[bus.raddr];
  assign scan_char = scan_q;
endmodule

// ===== cdr_glyph_ram.sv
// module: glyph pattern RAM with host port and font row port
`timescale 1ns/1ns
module cdr_glyph_ram #(
  parameter int DEPTH = 64
)(
  // clock
  input wire logic pclk,
  // host side
  cdr_ram_if.mem bus,
  // font fetch
  input wire logic [$clog2(DEPTH)-1:0] row_addr,
  output logic [7:0] row_data
);
  logic [7:0] mem [DEPTH];
  logic [7:0] row_q;

  // contents are undefined until software loads them
  always_ff @(posedge pclk)
  begin
    if (bus.we)
      mem[bus.waddr] <= bus.wdata;
    row_q <= mem[row_addr];
  end

  assign bus.rdata = mem[bus.raddr];
  assign row_data = row_q;
endmodule

// ===== cdr_top.sv
// module: host instruction port, counter, RAM access and reset state
`timescale 1ns/1ns
module cdr_top
  import cdr_pkg::*;
#(
  parameter int TEXT_DEPTH = CDR_TEXT_DEPTH,
  parameter int GLYPH_DEPTH = CDR_GLYPH_DEPTH
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CDR_ADDR_W-1:0] paddr,
  input wire logic [CDR_DATA_W-1:0] pwdata,
  output logic [CDR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // static strap
  input wire logic [1:0] host_mode_strap,
  // refresh and font fetch
  input wire logic [$clog2(TEXT_DEPTH)-1:0] scan_addr,
  output logic [7:0] scan_char,
  input wire logic [$clog2(GLYPH_DEPTH)-1:0] glyph_row_addr,
  output logic [7:0] glyph_row_data,
  // display settings
  output logic display_on,
  output logic cursor_on,
  output logic blink_en,
  output logic display_lines,
  output logic [1:0] luminance_level,
  output logic [6:0] shift_offset,
  output logic [6:0] cursor_addr
);
  localparam int TAW = $clog2(TEXT_DEPTH);
  localparam int GAW = $clog2(GLYPH_DEPTH);
  localparam logic [TAW-1:0] TEXT_LAST = TAW'(TEXT_DEPTH - 1);

  if (TEXT_DEPTH < 2 || TEXT_DEPTH > CDR_TEXT_DEPTH ||
      (TEXT_DEPTH & (TEXT_DEPTH - 1)) != 0)
  begin : g_bad_text
    $error("text depth must be a power of two from 2 to 128");
  end
  if (GLYPH_DEPTH < 2 || GLYPH_DEPTH > CDR_GLYPH_DEPTH ||
      (GLYPH_DEPTH & (GLYPH_DEPTH - 1)) != 0)
  begin : g_bad_glyph
    $error("glyph depth must be a power of two from 2 to 64");
  end

  // step the counter; glyph addressing stays inside six bits
  function automatic logic [6:0] cnt_step(input logic [6:0] v,
                                          input logic up,
                                          input logic narrow);
    logic [6:0] n;
    n = up ? 7'(v + 7'h01) : 7'(v - 7'h01);
    if (narrow)
      n[6] = 1'b0;
    return n;
  endfunction

  cdr_ram_if #(.AW(TAW)) text_bus ();
  cdr_ram_if #(.AW(GAW)) glyph_bus ();

  // control state
  logic [6:0] addr_cnt_q;
  logic [6:0] addr_cnt_d;
  logic [6:0] shift_q;
  logic [6:0] shift_d;
  logic sel_glyph_q;
  logic sel_glyph_d;
  logic inc_q;
  logic inc_d;
  logic shift_en_q;
  logic shift_en_d;
  logic disp_q;
  logic disp_d;
  logic cursor_q;
  logic cursor_d;
  logic blink_q;
  logic blink_d;
  logic bus_width_q;
  logic bus_width_d;
  logic lines_q;
  logic lines_d;
  logic [1:0] lum_q;
  logic [1:0] lum_d;
  logic start_clear;
  // fill sweep
  logic clr_busy_q;
  logic [TAW-1:0] clr_idx_q;
  // bus and nibble state
  logic ready_q;
  logic [CDR_DATA_W-1:0] prdata_q;
  logic nib_low_q;
  logic [3:0] nib_q;
  cdr_mode_t host_mode_q;
  logic strap_taken_q;
  logic [CDR_DATA_W-1:0] status_word;

  // apb decode
  wire hit_instr = paddr == CDR_OFF_INSTR;
  wire hit_data = paddr == CDR_OFF_DATA;
  wire hit_status = paddr == CDR_OFF_STATUS;
  wire unmapped = ~(hit_instr | hit_data | hit_status);
  // the sweep stalls every transfer so no access sees a half-filled RAM
  wire acc_wait = psel & penable & ~ready_q & ~clr_busy_q;
  wire done = psel & penable & ready_q;

  wire nib_mode = (host_mode_q != CDR_MODE_SERIAL) & ~bus_width_q;
  wire byte_end = ~nib_mode | nib_low_q;
  wire port_acc = done & (hit_instr | hit_data);
  wire [7:0] wr_byte = nib_mode ? {nib_q, pwdata[7:4]} : pwdata[7:0];
  wire exec_cmd = port_acc & hit_instr & pwrite & byte_end;
  wire exec_wr = port_acc & hit_data & pwrite & byte_end;
  wire exec_rd = port_acc & hit_data & ~pwrite & byte_end;

  // instruction class, leading one decides
  wire is_dset = wr_byte[7];
  wire is_gset = wr_byte[7:6] == CDR_PFX_GSET;
  wire is_func = wr_byte[7:5] == CDR_PFX_FUNC;
  wire is_curs = wr_byte[7:4] == CDR_PFX_CURS;
  wire is_onoff = wr_byte[7:3] == CDR_PFX_ONOFF;
  wire is_entry = wr_byte[7:2] == CDR_PFX_ENTRY;
  wire is_home = wr_byte[7:1] == CDR_PFX_HOME;
  wire is_clear = wr_byte == CDR_CMD_CLEAR;

  wire [7:0] ram_byte = sel_glyph_q ? glyph_bus.rdata : text_bus.rdata;
  wire [7:0] cnt_byte = {1'b0, addr_cnt_q};
  wire [7:0] port_byte = hit_data ? ram_byte : cnt_byte;
  wire [7:0] port_hi = {port_byte[7:4], 4'h0};
  wire [7:0] port_lo = {port_byte[3:0], 4'h0};
  wire [7:0] port_rd = ~nib_mode ? port_byte : nib_low_q ? port_lo : port_hi;
  wire [CDR_DATA_W-1:0] rd_word =
    hit_status ? status_word :
    unmapped ? '0 : {24'h0, port_rd};

  always_comb
  begin
    status_word = '0;
    status_word[CDR_ST_MODE +: 2] = host_mode_q;
    status_word[CDR_ST_DISP] = disp_q;
    status_word[CDR_ST_CURSOR] = cursor_q;
    status_word[CDR_ST_BLINK] = blink_q;
    status_word[CDR_ST_INC] = inc_q;
    status_word[CDR_ST_SHIFT_EN] = shift_en_q;
    status_word[CDR_ST_WIDTH] = bus_width_q;
    status_word[CDR_ST_LINES] = lines_q;
    status_word[CDR_ST_LUM +: 2] = lum_q;
    status_word[CDR_ST_GLYPH] = sel_glyph_q;
    status_word[CDR_ST_CLEAR] = clr_busy_q;
    status_word[CDR_ST_OFFSET +: 7] = shift_q;
  end

  // instruction and data execution
  always_comb
  begin
    addr_cnt_d = addr_cnt_q;
    shift_d = shift_q;
    sel_glyph_d = sel_glyph_q;
    inc_d = inc_q;
    shift_en_d = shift_en_q;
    disp_d = disp_q;
    cursor_d = cursor_q;
    blink_d = blink_q;
    bus_width_d = bus_width_q;
    lines_d = lines_q;
    lum_d = lum_q;
    start_clear = 1'b0;
    if (exec_cmd)
    begin
      if (is_dset)
      begin
        addr_cnt_d = wr_byte[6:0];
        sel_glyph_d = 1'b0;
      end
      else if (is_gset)
      begin
        addr_cnt_d = {1'b0, wr_byte[5:0]};
        sel_glyph_d = 1'b1;
      end
      else if (is_func)
      begin
        bus_width_d = wr_byte[CDR_FN_WIDTH];
        lines_d = wr_byte[CDR_FN_LINES];
        lum_d = wr_byte[CDR_FN_LUM +: 2];
      end
      else if (is_curs)
      begin
        addr_cnt_d = cnt_step(addr_cnt_q, wr_byte[CDR_CS_RIGHT], 1'b0);
        sel_glyph_d = 1'b0;
        // a left shift raises the offset, a right shift lowers it
        if (wr_byte[CDR_CS_DISPLAY])
          shift_d = cnt_step(shift_q, ~wr_byte[CDR_CS_RIGHT], 1'b0);
      end
      else if (is_onoff)
      begin
        disp_d = wr_byte[CDR_OO_DISP];
        cursor_d = wr_byte[CDR_OO_CURSOR];
        blink_d = wr_byte[CDR_OO_BLINK];
      end
      else if (is_entry)
      begin
        inc_d = wr_byte[CDR_EN_INC];
        shift_en_d = wr_byte[CDR_EN_SHIFT];
      end
      else if (is_home)
      begin
        addr_cnt_d = CDR_CNT_RST;
        shift_d = CDR_SHIFT_RST;
        sel_glyph_d = 1'b0;
      end
      else if (is_clear)
      begin
        addr_cnt_d = CDR_CNT_RST;
        shift_d = CDR_SHIFT_RST;
        inc_d = CDR_INC_RST;
        sel_glyph_d = 1'b0;
        start_clear = 1'b1;
      end
    end
    if (exec_wr)
    begin
      addr_cnt_d = cnt_step(addr_cnt_q, inc_q, sel_glyph_q);
      if (~sel_glyph_q & shift_en_q)
        shift_d = cnt_step(shift_q, inc_q, 1'b0);
    end
    if (exec_rd)
      addr_cnt_d = cnt_step(addr_cnt_q, inc_q, sel_glyph_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_cnt_q <= CDR_CNT_RST;
      shift_q <= CDR_SHIFT_RST;
      sel_glyph_q <= 1'b0;
      inc_q <= CDR_INC_RST;
      shift_en_q <= CDR_SHIFT_EN_RST;
      disp_q <= CDR_DISP_RST;
      cursor_q <= CDR_CURSOR_RST;
      blink_q <= CDR_BLINK_RST;
      bus_width_q <= CDR_WIDTH_RST;
      lines_q <= CDR_LINES_RST;
      lum_q <= CDR_LUM_RST;
    end
    else
    begin
      addr_cnt_q <= addr_cnt_d;
      shift_q <= shift_d;
      sel_glyph_q <= sel_glyph_d;
      inc_q <= inc_d;
      shift_en_q <= shift_en_d;
      disp_q <= disp_d;
      cursor_q <= cursor_d;
      blink_q <= blink_d;
      bus_width_q <= bus_width_d;
      lines_q <= lines_d;
      lum_q <= lum_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_busy_q <= 1'b1;
      clr_idx_q <= '0;
    end
    else if (clr_busy_q)
    begin
      clr_idx_q <= TAW'(clr_idx_q + 1'b1);
      if (clr_idx_q == TEXT_LAST)
        clr_busy_q <= 1'b0;
    end
    else if (start_clear)
    begin
      clr_busy_q <= 1'b1;
      clr_idx_q <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_mode_q <= CDR_MODE_PAR_A;
      strap_taken_q <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      // the unused code falls back to the shipped mode
      case (host_mode_strap)
        2'b01: host_mode_q <= CDR_MODE_PAR_B;
        2'b11: host_mode_q <= CDR_MODE_SERIAL;
        default: host_mode_q <= CDR_MODE_PAR_A;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nib_low_q <= 1'b0;
      nib_q <= 4'h0;
    end
    else if (!nib_mode)
      nib_low_q <= 1'b0;
    else if (port_acc)
    begin
      nib_low_q <= ~nib_low_q;
      if (pwrite & ~nib_low_q)
        nib_q <= pwdata[7:4];
    end
  end

  // one wait state: read data is sampled before any side effect lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      ready_q <= acc_wait;
      if (acc_wait)
        prdata_q <= rd_word;
    end
  end

  // RAM hookup
  assign text_bus.we = clr_busy_q | (exec_wr & ~sel_glyph_q);
  assign text_bus.waddr = clr_busy_q ? clr_idx_q : addr_cnt_q[TAW-1:0];
  assign text_bus.wdata = clr_busy_q ? CDR_SPACE_CODE : wr_byte;
  assign text_bus.raddr = addr_cnt_q[TAW-1:0];
  assign glyph_bus.we = exec_wr & sel_glyph_q;
  assign glyph_bus.waddr = addr_cnt_q[GAW-1:0];
  assign glyph_bus.wdata = wr_byte;
  assign glyph_bus.raddr = addr_cnt_q[GAW-1:0];

  cdr_text_ram #(.DEPTH(TEXT_DEPTH)) u_text (
    .pclk(pclk),
    .bus(text_bus),
    .scan_addr(scan_addr),
    .scan_char(scan_char)
  );

  cdr_glyph_ram #(.DEPTH(GLYPH_DEPTH)) u_glyph (
    .pclk(pclk),
    .bus(glyph_bus),
    .row_addr(glyph_row_addr),
    .row_data(glyph_row_data)
  );

  // outputs
  assign prdata = prdata_q;
  assign pready = ready_q;
  assign pslverr = ready_q & unmapped;
  assign display_on = disp_q;
  assign cursor_on = cursor_q;
  assign blink_en = blink_q;
  assign display_lines = lines_q;
  assign luminance_level = lum_q;
  assign shift_offset = shift_q;
  assign cursor_addr = addr_cnt_q;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_byte_read;
    exec_rd && !nib_mode;
  endsequence

  sequence s_first_cycle;
    !strap_taken_q;
  endsequence

  AST_BUSY_ZERO: assert property (
    done && hit_instr && !pwrite && !nib_mode |->
      prdata[7] == 1'b0 && prdata[6:0] == addr_cnt_q)
    else $error("counter read shows busy or wrong count");
  AST_TEXT_READ: assert property (
    s_byte_read and !sel_glyph_q |-> prdata[7:0] == text_bus.rdata)
    else $error("text read returned wrong byte");
  AST_GLYPH_READ: assert property (
    s_byte_read and sel_glyph_q |-> prdata[7:0] == glyph_bus.rdata)
    else $error("glyph read returned wrong byte");
  AST_READ_STEP: assert property (
    s_byte_read and inc_q and !sel_glyph_q |=>
      addr_cnt_q == 7'($past(addr_cnt_q) + 7'h01))
    else $error("counter did not step after read");
  AST_DEC_STEP: assert property (
    exec_wr && !inc_q && !sel_glyph_q |=>
      addr_cnt_q == 7'($past(addr_cnt_q) - 7'h01))
    else $error("counter did not decrement after write");
  AST_SPACE_FILL: assert property (
    clr_busy_q |-> text_bus.we && text_bus.wdata == CDR_SPACE_CODE && !pready)
    else $error("sweep not writing spaces");
  AST_FILL_END: assert property (
    clr_busy_q && clr_idx_q == TEXT_LAST |=> !clr_busy_q)
    else $error("sweep did not end after last location");
  AST_RESET_CNT: assert property (
    s_first_cycle |-> addr_cnt_q == CDR_CNT_RST && !sel_glyph_q)
    else $error("counter not at zero after reset");
  AST_RESET_SHIFT: assert property (
    s_first_cycle |-> shift_q == CDR_SHIFT_RST)
    else $error("shift offset not cleared by reset");
  AST_RESET_ENTRY: assert property (
    s_first_cycle |-> inc_q && !shift_en_q)
    else $error("entry bits wrong after reset");
  AST_RESET_ONOFF: assert property (
    s_first_cycle |-> !display_on && !cursor_on && !blink_en)
    else $error("display bits wrong after reset");
  AST_RESET_FUNC: assert property (
    s_first_cycle |-> bus_width_q && display_lines && luminance_level == 2'h0)
    else $error("function bits wrong after reset");
  AST_STRAP_HOLD: assert property (
    strap_taken_q |=> $stable(host_mode_q))
    else $error("host mode changed after strap capture");
  AST_DSET_LOAD: assert property (
    exec_cmd && is_dset |=>
      addr_cnt_q == $past(wr_byte[6:0]) && !sel_glyph_q)
    else $error("address set did not load counter");
  AST_NIBBLE_ORDER: assert property (
    port_acc && nib_mode && !nib_low_q ##1 !port_acc [*1] |->
      nib_low_q)
    else $error("nibble phase did not advance");
endmodule

// ===== cdr_host_model.sv
// host processor model: apb master for the display controller port
`timescale 1ns/1ns
module cdr_host_model
  import cdr_pkg::*;
(
  // clock
  input wire logic pclk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [CDR_ADDR_W-1:0] paddr,
  output logic [CDR_DATA_W-1:0] pwdata,
  input wire logic [CDR_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // waits that ran out
  output int hang_count
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hang_count = 0;
  end

  // one transfer; the request stands until pready is seen at an edge or 400 edges have passed
  task automatic xfer(input logic wr, input logic [7:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 400);
    if (n >= 400)
      hang_count++;
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    pwdata <= ~wdata;
    paddr <= ~addr;
  endtask
endmodule

// ===== cdr_top_tb.sv
// self-checking bench for the display read and reset block
`timescale 1ns/1ns
module cdr_top_tb
  import cdr_pkg::*;
;
  // small text RAM keeps the space fill sweep short
  localparam int TD = 8;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic [CDR_ADDR_W-1:0] paddr;
  logic [CDR_DATA_W-1:0] pwdata;
  logic [CDR_DATA_W-1:0] prdata;
  logic [1:0] host_mode_strap;
  logic [2:0] scan_addr;
  logic [5:0] glyph_row_addr;
  logic [7:0] scan_char;
  logic [7:0] glyph_row_data;
  logic display_on;
  logic cursor_on;
  logic blink_en;
  logic display_lines;
  logic [1:0] luminance_level;
  logic [6:0] shift_offset;
  logic [6:0] cursor_addr;
  logic [31:0] rd;
  logic err;
  int hang_count;
  int failures;
  int samples_checked;
  logic [1:0] straps [3] = '{2'b01, 2'b11, 2'b10};
  logic [1:0] modes [3] = '{2'b01, 2'b11, 2'b00};

  cdr_top #(.TEXT_DEPTH(TD), .GLYPH_DEPTH(64)) cdr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .host_mode_strap(host_mode_strap), .scan_addr(scan_addr),
    .scan_char(scan_char), .glyph_row_addr(glyph_row_addr),
    .glyph_row_data(glyph_row_data), .display_on(display_on),
    .cursor_on(cursor_on), .blink_en(blink_en),
    .display_lines(display_lines), .luminance_level(luminance_level),
    .shift_offset(shift_offset), .cursor_addr(cursor_addr)
  );

  cdr_host_model cdr_host_model_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hang_count(hang_count)
  );

  always #50 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cdr_host_model_i.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] mask);
    cdr_host_model_i.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd & mask, exp);
  endtask

  task automatic do_reset(input logic [1:0] strap);
    @(posedge pclk);
    presetn <= 1'b0;
    host_mode_strap <= strap;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic summarize();
    failures += hang_count;
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    host_mode_strap = 2'b00;
    scan_addr = 3'h0;
    glyph_row_addr = 6'h0;
    failures = 0;
    samples_checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // status: inc, 8-bit, two lines set; all else clear
    rd_chk(CDR_OFF_STATUS, 32'h0000_01a0, 32'h007f_1fff);
    chk({display_on, cursor_on, blink_en, display_lines, luminance_level,
      shift_offset, cursor_addr}, 32'h0001_0000);
    rd_chk(CDR_OFF_INSTR, 32'h0, 32'hff);
    for (int i = 0; i < TD; i++)
      rd_chk(CDR_OFF_DATA, {24'h0, CDR_SPACE_CODE}, 32'hff);
    rd_chk(CDR_OFF_INSTR, TD, 32'hff);
    scan_addr <= 3'h5;
    repeat (2) @(posedge pclk);
    chk(scan_char, CDR_SPACE_CODE);
    // text at 3, glyph at 5 and 6; reads follow the last address set
    wr(CDR_OFF_INSTR, 32'h83);
    wr(CDR_OFF_DATA, 32'h41);
    wr(CDR_OFF_INSTR, 32'h45);
    wr(CDR_OFF_DATA, 32'ha5);
    wr(CDR_OFF_DATA, 32'h5a);
    wr(CDR_OFF_INSTR, 32'h45);
    rd_chk(CDR_OFF_DATA, 32'ha5, 32'hff);
    rd_chk(CDR_OFF_DATA, 32'h5a, 32'hff);
    rd_chk(CDR_OFF_INSTR, 32'h07, 32'hff);
    wr(CDR_OFF_INSTR, 32'h83);
    rd_chk(CDR_OFF_DATA, 32'h41, 32'hff);
    glyph_row_addr <= 6'h6;
    repeat (2) @(posedge pclk);
    chk(glyph_row_data, 32'h5a);
    // decrement steps, glyph counter wraps in six bits
    wr(CDR_OFF_INSTR, 32'h04);
    wr(CDR_OFF_INSTR, 32'h82);
    rd_chk(CDR_OFF_DATA, 32'h20, 32'hff);
    rd_chk(CDR_OFF_INSTR, 32'h01, 32'hff);
    wr(CDR_OFF_DATA, 32'h33);
    rd_chk(CDR_OFF_INSTR, 32'h00, 32'hff);
    wr(CDR_OFF_INSTR, 32'h40);
    wr(CDR_OFF_DATA, 32'h77);
    rd_chk(CDR_OFF_INSTR, 32'h3f, 32'hff);
    wr(CDR_OFF_INSTR, 32'h40);
    rd_chk(CDR_OFF_DATA, 32'h77, 32'hff);
    rd_chk(CDR_OFF_INSTR, 32'h3f, 32'hff);
    wr(CDR_OFF_INSTR, 32'h06);
    // unmapped address answers with an error
    cdr_host_model_i.xfer(1'b0, 8'h0c, 32'h0, rd, err);
    chk(err, 32'h1);
    // settings, write shift, cursor shifts, home and clear
    wr(CDR_OFF_INSTR, 32'h0f);
    wr(CDR_OFF_INSTR, 32'h07);
    wr(CDR_OFF_INSTR, 32'h80);
    wr(CDR_OFF_DATA, 32'h55);
    wr(CDR_OFF_INSTR, 32'h18);
    wr(CDR_OFF_INSTR, 32'h1c);
    wr(CDR_OFF_INSTR, 32'h14);
    // outputs are looked at half a cycle after the edge that sets them
    @(negedge pclk);
    chk({display_on, cursor_on, blink_en, display_lines, luminance_level,
      shift_offset, cursor_addr}, 32'h000f_0082);
    wr(CDR_OFF_INSTR, 32'h02);
    @(negedge pclk);
    chk({shift_offset, cursor_addr}, 32'h0);
    wr(CDR_OFF_INSTR, 32'h05);
    wr(CDR_OFF_INSTR, 32'h01);
    rd_chk(CDR_OFF_DATA, 32'h20, 32'hff);
    rd_chk(CDR_OFF_INSTR, 32'h01, 32'hff);
    // shift stays enabled: a read must leave the offset at zero
    rd_chk(CDR_OFF_STATUS, 32'h0000_01fc, 32'h007f_1ffc);
    wr(CDR_OFF_INSTR, 32'h83);
    wr(CDR_OFF_DATA, 32'h41);
    // four-bit mode: nibbles in bits 7:4, high first
    wr(CDR_OFF_INSTR, 32'h28);
    wr(CDR_OFF_INSTR, 32'h80);
    wr(CDR_OFF_INSTR, 32'h30);
    rd_chk(CDR_OFF_DATA, 32'h40, 32'hf0);
    rd_chk(CDR_OFF_DATA, 32'h10, 32'hf0);
    rd_chk(CDR_OFF_INSTR, 32'h00, 32'hf0);
    rd_chk(CDR_OFF_INSTR, 32'h40, 32'hf0);
    // each strap setting but 00, with a reset in mid-run
    for (int i = 0; i < 3; i++)
    begin
      do_reset(straps[i]);
      rd_chk(CDR_OFF_STATUS, {30'h0, modes[i]}, 32'h3);
      rd_chk(CDR_OFF_INSTR, 32'h0, 32'hff);
    end
    rd_chk(CDR_OFF_STATUS, 32'h0000_0180, 32'h0000_0780);
    summarize();
  end
endmodule
